// ==== rtl/qaops_pkg.sv ====
/*
  constants, carriers and helpers shared by the output port sequencer.
  assumes one link clock cycle equals half a converter clock period.
*/
// What this block does
// RULE_01: port latency follows channel mode and port
// RULE_02: ready restarts one clock plus 1.8 ns after resync
// RULE_03: resync pulse lasts at least five clocks
// RULE_04: resync pin never changes in forbidden window
// RULE_05: ready stops, or keeps running, per mode
// RULE_06: two-channel mode routes two chosen inputs
// RULE_07: one-channel mode digitises one chosen input
// RULE_08: nine-bit words, binary or gray coded
// RULE_09: binary mid-scale sits at code 100000000
// RULE_10: receiver derives in-range from bits 7, 8
// RULE_11: receiver subtracts offset for plain codes
// RULE_12: one-channel samples rotate C, B, D, A
package qaops_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] STAT_OFS       = 12'h004;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  // status field positions
  localparam int          STAT_SYNC_BIT  = 0;
  localparam int          STAT_RUN_BIT   = 1;
  localparam int          STAT_SHORT_BIT = 2;

  // channel modes; code 3 is illegal and acts as four-channel
  localparam logic [1:0]  MODE_4CH       = 2'h0;
  localparam logic [1:0]  MODE_2CH       = 2'h1;
  localparam logic [1:0]  MODE_1CH       = 2'h2;

  // pipeline latency in half converter clocks (7, 8, 7, 8, 7, 7.5, 6.5 clocks)
  localparam logic [4:0]  LAT_4CH_HALF   = 5'h0e;
  localparam logic [4:0]  LAT_2CH_AC     = 5'h10;
  localparam logic [4:0]  LAT_2CH_BD     = 5'h0e;
  localparam logic [4:0]  LAT_1CH_A      = 5'h10;
  localparam logic [4:0]  LAT_1CH_B      = 5'h0e;
  localparam logic [4:0]  LAT_1CH_C      = 5'h0f;
  localparam logic [4:0]  LAT_1CH_D      = 5'h0d;
  // line tap sits three stages short of the latency (din stage, read reg, port hold reg)
  localparam logic [4:0]  LAT_TAP_OFS    = 5'h03;

  // timing: link cycle is half a converter period
  localparam int          LINK_PERIOD_PS = 15000;
  localparam int          RDY_EXTRA_PS   = 1800;
  localparam int          RESTART_CYC    = 2 + (RDY_EXTRA_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int          RESYNC_MIN_CLK = 5;
  localparam logic [3:0]  RESYNC_MIN_CYC = 4'(2 * RESYNC_MIN_CLK);

  // control register layout
  typedef struct packed {
    logic       ready_mode_select;
    logic       gray;
    logic [1:0] sel_one;
    logic       sel_cd;
    logic       sel_ab;
    logic [1:0] mode;
  } qaops_ctrl_t;

  // one pipeline word: sample marker and coded data
  typedef struct packed {
    logic       vld;
    logic [8:0] data;
  } qaops_word_t;

  typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_RESTART} qaops_seq_t;

  // binary to reflected gray, bit 8 most significant
  function automatic logic [8:0] gray9(input logic [8:0] b);
    gray9 = b ^ (b >> 1);
  endfunction : gray9

  // latency of one port (0=A .. 3=D) in half clocks
  function automatic logic [4:0] lat_half(input logic [1:0] mode, input logic [1:0] port);
    logic [4:0] l;
    l = LAT_4CH_HALF;
    if (mode == MODE_2CH)
      l = port[0] ? LAT_2CH_BD : LAT_2CH_AC;
    else if (mode == MODE_1CH)
    begin
      unique case (port)
        2'h0: l = LAT_1CH_A;
        2'h1: l = LAT_1CH_B;
        2'h2: l = LAT_1CH_C;
        2'h3: l = LAT_1CH_D;
      endcase
    end
    lat_half = l;
  endfunction : lat_half

endpackage : qaops_pkg

// ==== rtl/qaops_lat_line.sv ====
/*
  tapped shift line that delays sample words by a selectable count.
  assumes tap is held steady while words that use it are in flight.
*/
`timescale 1ns/1ps
`default_nettype none
module qaops_lat_line #(
  parameter int W = 10,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // data
  input  wire logic [W-1:0]         din_i,
  input  wire logic [$clog2(D)-1:0] tap_i,
  output logic      [W-1:0]         dout_q
);

  // stages of the line
  logic [D-1:0][W-1:0] mem_q;

  if (D < 2)
    $error("qaops_lat_line needs at least two stages");

  // shift every cycle; reset clears stale markers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mem_q <= '0;
    else
      mem_q <= {mem_q[D-2:0], din_i};
  end

  // registered read of the chosen stage
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dout_q <= '0;
    else
      dout_q <= mem_q[tap_i];
  end

endmodule : qaops_lat_line
`default_nettype wire

// ==== rtl/qaops_seq.sv ====
/*
  output port sequencer: apb control on the system clock, sample
  routing, coding, latency and ready strobes on the link clock.
  assumes the four cores return a sample in the cycle it is commanded,
  and that software changes control only while the link is quiet.
*/
`timescale 1ns/1ps
`default_nettype none
module qaops_seq #(
  parameter int LINE_DEPTH = 16
) (
  // system clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // link clock and resync pin pair
  input  wire logic        LINK_CLK_I,
  input  wire logic        RESYNC_PULSE_POS_I,
  input  wire logic        RESYNC_PULSE_NEG_I,
  // converter cores
  input  wire logic [3:0][8:0] CORE_SAMPLE_I,
  output logic      [3:0]      SAMPLE_CMD_O,
  output logic      [3:0][1:0] INPUT_SEL_O,
  // output ports
  output logic      [8:0]  PORT_A_SAMPLE_BITS_O,
  output logic      [8:0]  PORT_B_SAMPLE_BITS_O,
  output logic      [8:0]  PORT_C_SAMPLE_BITS_O,
  output logic      [8:0]  PORT_D_SAMPLE_BITS_O,
  output logic             PORT_A_READY_STROBE_O,
  output logic             PORT_B_READY_STROBE_O,
  output logic             PORT_C_READY_STROBE_O,
  output logic             PORT_D_READY_STROBE_O
);

  localparam int TW = $clog2(LINE_DEPTH);

  // the longest latency tap must exist in the line
  if (LINE_DEPTH < 14)
    $error("qaops_seq needs LINE_DEPTH of at least 14");

  // system side state
  qaops_pkg::qaops_ctrl_t ctrl_q;        // control register
  logic                   short_q;       // sticky short resync flag
  logic                   pready_q;      // apb answer
  logic [31:0]            prdata_q;      // apb read data
  logic                   pslverr_q;     // apb error
  logic [1:0]             sync_m_q;      // resync level, crossing
  logic [1:0]             run_m_q;       // running level, crossing
  logic [2:0]             shtg_m_q;      // short toggle, crossing plus edge stage

  // link side state
  logic [1:0]             lrst_q;        // link reset release
  qaops_pkg::qaops_ctrl_t ctrl_m_q;      // control, first stage
  qaops_pkg::qaops_ctrl_t ctrl_s_q;      // control, link copy
  logic                   syn_m_q;       // resync pin, first stage
  logic                   syn_s_q;       // resync pin, usable
  qaops_pkg::qaops_seq_t  state_q;       // resync sequencer
  logic [1:0]             cnt_q;         // restart delay count
  logic [3:0]             wid_q;         // resync width, saturating
  logic                   short_tgl_q;   // toggles on each short pulse
  logic                   run_q;         // registered running flag
  logic [1:0]             phase_q;       // sample slot rotation
  logic [3:0]             cmd_q;         // per core sample command
  logic [3:0][1:0]        sel_q;         // per core input choice
  logic [3:0][8:0]        port_q;        // held output words
  logic [3:0]             rdy_q;         // ready strobes, toggle per word
  logic [3:0][8:0]        enc;           // coded core samples
  qaops_pkg::qaops_word_t [3:0] lw;      // words leaving the lines
  logic                   lrst_n;        // link reset, active low
  logic                   issue;         // sample slots advance
  logic                   apb_setup;     // apb setup phase
  logic                   apb_wr;        // apb write completes

  assign lrst_n    = lrst_q[1];
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr    = PSEL_I && PENABLE_I && pready_q && PWRITE_I;

  // apb: answer one cycle after setup, data and error latched in setup
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= apb_setup;
      if (apb_setup)
      begin
        pslverr_q <= (PADDR_I != qaops_pkg::CTRL_OFS) && (PADDR_I != qaops_pkg::STAT_OFS);
        prdata_q  <= 32'h0000_0000;
        if (!PWRITE_I && PADDR_I == qaops_pkg::CTRL_OFS)
          prdata_q <= {24'h00_0000, ctrl_q};
        else if (!PWRITE_I && PADDR_I == qaops_pkg::STAT_OFS)
        begin
          prdata_q[qaops_pkg::STAT_SYNC_BIT]  <= sync_m_q[1];
          prdata_q[qaops_pkg::STAT_RUN_BIT]   <= run_m_q[1];
          prdata_q[qaops_pkg::STAT_SHORT_BIT] <= short_q;
        end
      end
    end
  end

  // control register write
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      ctrl_q <= qaops_pkg::CTRL_RST;
    else if (apb_wr && PADDR_I == qaops_pkg::CTRL_OFS)
      ctrl_q <= PWDATA_I[7:0];
  end

  // status crossings from the link side
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sync_m_q <= 2'h0;
      run_m_q  <= 2'h0;
      shtg_m_q <= 3'h0;
    end
    else
    begin
      sync_m_q <= {sync_m_q[0], syn_s_q};
      run_m_q  <= {run_m_q[0], run_q};
      shtg_m_q <= {shtg_m_q[1:0], short_tgl_q};
    end
  end

  // short resync flag: a new event beats a write-one clear in the same cycle
  always_ff @(posedge MCLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      short_q <= 1'b0;
    else if (shtg_m_q[2] != shtg_m_q[1])
      short_q <= 1'b1; // RULE_03
    else if (apb_wr && PADDR_I == qaops_pkg::STAT_OFS && PWDATA_I[qaops_pkg::STAT_SHORT_BIT])
      short_q <= 1'b0;
  end

  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = pready_q;
  assign PSLVERR_O = pslverr_q;

  // link reset: asserted at once, released on the link clock
  always_ff @(posedge LINK_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      lrst_q <= 2'h0;
    else
      lrst_q <= {lrst_q[0], 1'b1};
  end

  // control and resync pin into the link domain; control is quasi-static,
  // so a per-bit pair suffices as long as software writes while quiet
  always_ff @(posedge LINK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      ctrl_m_q <= qaops_pkg::CTRL_RST;
      ctrl_s_q <= qaops_pkg::CTRL_RST;
      syn_m_q  <= 1'b0;
      syn_s_q  <= 1'b0;
    end
    else
    begin
      ctrl_m_q <= ctrl_q;
      ctrl_s_q <= ctrl_m_q;
      syn_m_q  <= RESYNC_PULSE_POS_I && !RESYNC_PULSE_NEG_I; // RULE_04
      syn_s_q  <= syn_m_q;
    end
  end

  // resync sequencer: hold while the pulse stands, then a fixed restart gap
  always_ff @(posedge LINK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      state_q <= qaops_pkg::SEQ_RUN;
      cnt_q   <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        qaops_pkg::SEQ_RUN:
          if (syn_s_q)
            state_q <= qaops_pkg::SEQ_HOLD;
        qaops_pkg::SEQ_HOLD:
          if (!syn_s_q)
          begin
            state_q <= qaops_pkg::SEQ_RESTART;
            cnt_q   <= 2'h0;
          end
        qaops_pkg::SEQ_RESTART:
          if (syn_s_q)
            state_q <= qaops_pkg::SEQ_HOLD;
          else if (cnt_q == 2'(qaops_pkg::RESTART_CYC - 1))
            state_q <= qaops_pkg::SEQ_RUN; // RULE_02
          else
            cnt_q <= cnt_q + 2'h1;
      endcase
    end
  end

  // resync width check: a pulse shorter than five clocks is reported
  always_ff @(posedge LINK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      wid_q       <= 4'h0;
      short_tgl_q <= 1'b0;
      run_q       <= 1'b0;
    end
    else
    begin
      run_q <= (state_q == qaops_pkg::SEQ_RUN);
      if (syn_s_q)
        wid_q <= (wid_q == 4'hf) ? wid_q : wid_q + 4'h1;
      else
        wid_q <= 4'h0;
      if (!syn_s_q && state_q == qaops_pkg::SEQ_HOLD && wid_q < qaops_pkg::RESYNC_MIN_CYC)
        short_tgl_q <= !short_tgl_q; // RULE_03
    end
  end

  // slots advance while running, and through the hold of a resync when ready keeps going
  assign issue = (state_q == qaops_pkg::SEQ_RUN) ||
                 (state_q == qaops_pkg::SEQ_HOLD && ctrl_s_q.ready_mode_select); // RULE_05

  // sample commands; a restart begins the rotation afresh
  always_ff @(posedge LINK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      phase_q <= 2'h0;
      cmd_q   <= 4'h0;
    end
    else
    begin
      cmd_q <= 4'h0;
      if (state_q == qaops_pkg::SEQ_RESTART)
        phase_q <= 2'h0;
      else if (issue)
      begin
        phase_q <= phase_q + 2'h1;
        if (ctrl_s_q.mode == qaops_pkg::MODE_1CH)
        begin
          unique case (phase_q) // RULE_12
            2'h0: cmd_q <= 4'b0100;
            2'h1: cmd_q <= 4'b0010;
            2'h2: cmd_q <= 4'b1000;
            2'h3: cmd_q <= 4'b0001;
          endcase
        end
        else if (ctrl_s_q.mode == qaops_pkg::MODE_2CH)
          cmd_q <= phase_q[0] ? 4'b1010 : 4'b0101; // RULE_06
        else
          cmd_q <= phase_q[0] ? 4'b0000 : 4'b1111;
      end
    end
  end

  // input routing for each core
  always_ff @(posedge LINK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
      sel_q <= {2'h3, 2'h2, 2'h1, 2'h0};
    else if (ctrl_s_q.mode == qaops_pkg::MODE_2CH)
      sel_q <= {{1'b1, ctrl_s_q.sel_cd}, {1'b1, ctrl_s_q.sel_cd},
                {1'b0, ctrl_s_q.sel_ab}, {1'b0, ctrl_s_q.sel_ab}}; // RULE_06
    else if (ctrl_s_q.mode == qaops_pkg::MODE_1CH)
      sel_q <= {4{ctrl_s_q.sel_one}}; // RULE_07
    else
      sel_q <= {2'h3, 2'h2, 2'h1, 2'h0};
  end

  assign SAMPLE_CMD_O = cmd_q;
  assign INPUT_SEL_O  = sel_q;

  // per port: code, delay, hold and strobe
  for (genvar p = 0; p < 4; p++)
  begin : g_port
    logic [4:0] lat;
    assign lat    = qaops_pkg::lat_half(ctrl_s_q.mode, 2'(p));
    // binary keeps the core code (mid-scale 100000000); gray on request
    assign enc[p] = ctrl_s_q.gray ? qaops_pkg::gray9(CORE_SAMPLE_I[p]) : CORE_SAMPLE_I[p]; // RULE_08 RULE_09

    qaops_lat_line #(
      .W (10),
      .D (LINE_DEPTH)
    ) u_line (
      .clk_i   (LINK_CLK_I),
      .rst_n_i (lrst_n),
      .din_i   ({cmd_q[p], enc[p]}),
      .tap_i   (TW'(lat - qaops_pkg::LAT_TAP_OFS)), // RULE_01
      .dout_q  (lw[p])
    );

    // word held until the next one; ready toggles with every new word, but is held low in hold and restart unless ready keeps going
    always_ff @(posedge LINK_CLK_I or negedge lrst_n)
    begin
      if (!lrst_n)
      begin
        port_q[p] <= 9'h000;
        rdy_q[p]  <= 1'b0;
      end
      else
      begin
        if (lw[p].vld)
          port_q[p] <= lw[p].data; // RULE_01
        if (state_q != qaops_pkg::SEQ_RUN && !ctrl_s_q.ready_mode_select)
          rdy_q[p] <= 1'b0; // RULE_05
        else // strobes toggle in run, and through hold and restart only when ready keeps going
          rdy_q[p] <= rdy_q[p] ^ lw[p].vld; // RULE_05
      end
    end
  end

  assign PORT_A_SAMPLE_BITS_O  = port_q[0];
  assign PORT_B_SAMPLE_BITS_O  = port_q[1];
  assign PORT_C_SAMPLE_BITS_O  = port_q[2];
  assign PORT_D_SAMPLE_BITS_O  = port_q[3];
  assign PORT_A_READY_STROBE_O = rdy_q[0];
  assign PORT_B_READY_STROBE_O = rdy_q[1];
  assign PORT_C_READY_STROBE_O = rdy_q[2];
  assign PORT_D_READY_STROBE_O = rdy_q[3];

  // checks
  a_lat_four_a: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_01 RULE_08
    cmd_q[0] && ctrl_s_q.mode == qaops_pkg::MODE_4CH && $stable(ctrl_s_q) |-> ##14 port_q[0] == $past(enc[0], 14))
    else $error("port A four-channel word late or wrong");
  a_lat_one_d: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_01 RULE_08
    cmd_q[3] && ctrl_s_q.mode == qaops_pkg::MODE_1CH && $stable(ctrl_s_q) |-> ##13 port_q[3] == $past(enc[3], 13))
    else $error("port D one-channel word late or wrong");
  a_restart_gap: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_02
    $fell(syn_s_q) && state_q == qaops_pkg::SEQ_HOLD |=> state_q == qaops_pkg::SEQ_RESTART [*3] ##1 state_q == qaops_pkg::SEQ_RUN)
    else $error("ready restart delay wrong");
  a_ready_stops: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_05
    state_q == qaops_pkg::SEQ_HOLD && !ctrl_s_q.ready_mode_select |=> rdy_q == 4'h0 && cmd_q == 4'h0)
    else $error("ready not stopped during resync");
  a_order_cb: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_12
    cmd_q == 4'b0100 && issue && ctrl_s_q.mode == qaops_pkg::MODE_1CH |=> cmd_q == 4'b0010)
    else $error("one-channel rotation broken");
  a_route_two: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_06
    ctrl_s_q.mode == qaops_pkg::MODE_2CH && $stable(ctrl_s_q) |->
      sel_q[1] == {1'b0, ctrl_s_q.sel_ab} && sel_q[2] == {1'b1, ctrl_s_q.sel_cd})
    else $error("two-channel routing wrong");
  a_route_one: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_07
    ctrl_s_q.mode == qaops_pkg::MODE_1CH && $stable(ctrl_s_q) |-> sel_q[0] == ctrl_s_q.sel_one && sel_q[3] == sel_q[0])
    else $error("one-channel routing wrong");
  a_short_sync: assert property (@(posedge LINK_CLK_I) disable iff (!lrst_n) // RULE_03
    $fell(syn_s_q) && state_q == qaops_pkg::SEQ_HOLD && wid_q < qaops_pkg::RESYNC_MIN_CYC |=> $changed(short_tgl_q))
    else $error("short resync not reported");
  a_apb_answer: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    apb_setup |=> PREADY_O ##1 !PREADY_O)
    else $error("apb answer timing wrong");

endmodule : qaops_seq
`default_nettype wire

// ==== bench/qaops_rx_model.sv ====
/*
  receiving logic model: pairs every core command with the word that later
  shows on that port, and measures the delay in link cycles.
  assumes it runs on the link clock beside the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module qaops_rx_model (
  // link clock, reset, flush and expected coding
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            clr_i,
  input  wire logic            gray_i,
  // sequencer side
  input  wire logic [3:0]      cmd_i,
  input  wire logic [3:0][8:0] core_i,
  input  wire logic [3:0][8:0] port_i,
  input  wire logic [3:0]      rdy_i,
  // capture results
  output logic      [3:0][7:0] n_word_o,
  output logic      [3:0][7:0] n_bad_o,
  output logic      [3:0][7:0] lat_o,
  output logic      [3:0]      in_range_o,
  output logic      [3:0][8:0] twos_o
);
  logic [3:0]  rdy_q;    // strobe level at the last edge
  int          cyc_q;    // link cycle stamp
  logic [40:0] q[4][$];  // stamp and raw code awaiting its word
  logic [40:0] e;        // popped entry
  logic [8:0]  x;        // word the port should carry

  // any strobe edge is a new word; a word with no pending command is ignored
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdy_q    <= 4'h0;
      cyc_q    <= 0;
      n_word_o <= '0;
      n_bad_o  <= '0;
      lat_o    <= '0;
    end
    else
    begin
      cyc_q <= cyc_q + 1;
      rdy_q <= rdy_i;
      for (int k = 0; k < 4; k++)
      begin
        // flush only while nothing is in flight, or pairs slip
        if (clr_i)
        begin
          q[k].delete();
          n_word_o[k] <= 8'h00;
          n_bad_o[k]  <= 8'h00;
        end
        else if (rdy_i[k] !== rdy_q[k] && q[k].size() > 0)
        begin
          e = q[k].pop_front();
          x = gray_i ? e[8:0] ^ (e[8:0] >> 1) : e[8:0];
          lat_o[k]    <= 8'(cyc_q - int'(e[40:9]));
          n_word_o[k] <= n_word_o[k] + 8'h01;
          if (port_i[k] !== x)
            n_bad_o[k] <= n_bad_o[k] + 8'h01;
        end
        if (cmd_i[k] && !clr_i)
          q[k].push_back({cyc_q, core_i[k]});
        in_range_o[k] <= gray_i ? port_i[k][7] : port_i[k][8] ^ port_i[k][7];
        twos_o[k]     <= port_i[k] - 9'h100;
      end
    end
  end
endmodule : qaops_rx_model
`default_nettype wire

// ==== bench/qaops_seq_tb.sv ====
/*
  bench of the output port sequencer: apb master, core ramp, resync pair.
  assumes the sequencer's hand-over timing and the capture model.
*/
`timescale 1ns/1ps
`default_nettype none
module qaops_seq_tb;
  // apb master and stimulus
  logic                 mclk     = 1'b0;
  logic                 lclk     = 1'b0;
  logic                 rst_n    = 1'b0;
  logic                 psel     = 1'b0;
  logic                 pen      = 1'b0;
  logic                 pwrite   = 1'b0;
  logic [11:0]          paddr    = 12'h000;
  logic [31:0]          pwdata   = 32'h0;
  logic                 sync_q   = 1'b0;  // resync request; the pair follows it
  logic                 clr      = 1'b0;  // flush of the capture model
  logic                 gray     = 1'b0;
  logic                 fix      = 1'b0;  // hold all cores on fix_code
  logic [8:0]           fix_code = 9'h000;
  logic [8:0]           ramp     = 9'h000;
  logic [3:0][8:0]      core     = '0;
  logic [7:0]           ctrl_q   = 8'h00; // control last written
  // observed
  wire logic [31:0]     prdata;
  wire logic            pready;
  wire logic            pslverr;
  wire logic [3:0]      cmd;
  wire logic [3:0][1:0] isel;
  wire logic [3:0][8:0] port;
  wire logic [3:0]      rdy;
  wire logic [3:0][7:0] n_word;
  wire logic [3:0][7:0] n_bad;
  wire logic [3:0][7:0] lat;
  wire logic [3:0]      inr;
  wire logic [3:0][8:0] twos;
  int                   n_fail     = 0;
  int                   n_compared = 0;
  int                   ticks      = 0;

  // 50 ns system clock; 15 ns link clock whose rising edges never meet it
  always #25 mclk = ~mclk;
  always #7.5 lclk = ~lclk;

  // cores: a ramp with one phase per core, or one fixed code
  always @(posedge lclk)
  begin
    ramp <= ramp + 9'h007;
    for (int k = 0; k < 4; k++)
      core[k] <= fix ? fix_code : ramp + 9'(k * 64);
  end

  qaops_seq u_dut (
    .MCLK_I(mclk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LINK_CLK_I(lclk), .RESYNC_PULSE_POS_I(sync_q), .RESYNC_PULSE_NEG_I(!sync_q),
    .CORE_SAMPLE_I(core), .SAMPLE_CMD_O(cmd), .INPUT_SEL_O(isel),
    .PORT_A_SAMPLE_BITS_O(port[0]), .PORT_B_SAMPLE_BITS_O(port[1]),
    .PORT_C_SAMPLE_BITS_O(port[2]), .PORT_D_SAMPLE_BITS_O(port[3]),
    .PORT_A_READY_STROBE_O(rdy[0]), .PORT_B_READY_STROBE_O(rdy[1]),
    .PORT_C_READY_STROBE_O(rdy[2]), .PORT_D_READY_STROBE_O(rdy[3]));

  qaops_rx_model u_rx (
    .clk_i(lclk), .rst_n_i(rst_n), .clr_i(clr), .gray_i(gray), .cmd_i(cmd), .core_i(core),
    .port_i(port), .rdy_i(rdy), .n_word_o(n_word), .n_bad_o(n_bad), .lat_o(lat),
    .in_range_o(inr), .twos_o(twos));

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic cmp_in(input string what, input int lo, input int hi, input int got);
    n_compared++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("BAD %s expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask : cmp_in

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // a hang counts as a mismatch
  always @(posedge mclk)
  begin
    ticks <= ticks + 1;
    if (ticks == 5000)
    begin
      n_fail++;
      final_report;
    end
  end

  // one apb transfer; request held until ready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    r   = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // control changes only inside a held resync, while the link is quiet
  task automatic cfg(input logic [7:0] c);
    logic [31:0] r;
    logic        e;
    int          n;
    @(posedge lclk);
    sync_q <= 1'b1;
    // keep-running mode never quiets the link: stop it before the mode moves
    if (ctrl_q[7])
      apb(1'b1, 12'h000, 32'(ctrl_q & 8'h7f), r, e);
    repeat (20) @(posedge lclk);
    cmp("strobes held", 32'h0, 32'(rdy));
    cmp("commands held", 32'h0, 32'(cmd));
    clr  <= 1'b1;
    gray <= c[6];
    @(posedge lclk);
    clr <= 1'b0;
    apb(1'b1, 12'h000, 32'(c), r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    cmp("control", 32'(c), r);
    ctrl_q = c;
    @(posedge lclk);
    sync_q <= 1'b0;
    n = 0;
    while (!c[7] && cmd === 4'h0 && n < 40)
    begin
      @(posedge lclk);
      n++;
    end
    if (!c[7])
      cmp_in("restart cycles", 5, 9, n);
  endtask : cfg

  // one mode: routing, command order, latency and coded data per port
  task automatic t_run(input logic [7:0] c, input logic [7:0] sel, input logic [15:0] s,
                       input logic [31:0] l);
    int n;
    cfg(c);
    n = 0;
    while (cmd !== s[15:12] && n < 40)
    begin
      @(posedge lclk);
      n++;
    end
    for (int i = 1; i < 4; i++)
    begin
      @(posedge lclk);
      cmp("command order", 32'(s[15 - 4 * i -: 4]), 32'(cmd));
    end
    cmp("input select", 32'(sel), 32'(isel));
    repeat (60) @(posedge lclk);
    for (int k = 0; k < 4; k++)
    begin
      cmp("latency", 32'(l[8 * k +: 8]), 32'(lat[k]));
      cmp("bad words", 32'h0, 32'(n_bad[k]));
      cmp_in("words", 10, 255, int'(n_word[k]));
    end
  endtask : t_run

  // register readback and an unmapped place, write and read
  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b0, 12'h000, 32'h0, r, e);
    cmp("control reset", 32'h0, r);
    apb(1'b1, 12'h008, 32'hffff_ffff, r, e);
    cmp("unmapped write error", 32'h1, 32'(e));
    apb(1'b0, 12'h008, 32'h0, r, e);
    cmp("unmapped read", 32'h0, r);
    cmp("unmapped read error", 32'h1, 32'(e));
  endtask : t_regs

  // keep-running mode across a pulse shorter than the minimum width
  task automatic t_rm1;
    logic [31:0] r;
    logic        e;
    int          w;
    w = int'(n_word[0]);
    @(posedge lclk);
    sync_q <= 1'b1;
    repeat (6) @(posedge lclk);
    sync_q <= 1'b0;
    repeat (8) @(posedge lclk);
    cmp_in("words through resync", w + 2, 255, int'(n_word[0]));
    repeat (4) @(posedge mclk);
    apb(1'b0, 12'h004, 32'h0, r, e);
    cmp("short pulse flag", 32'h1, 32'(r[2]));
    apb(1'b1, 12'h004, 32'h4, r, e);
    apb(1'b0, 12'h004, 32'h0, r, e);
    cmp("short flag cleared", 32'h0, 32'(r[2]));
    cmp("bad words", 32'h0, 32'(n_bad));
  endtask : t_rm1

  // fixed binary codes: mid-scale, bottom of range, below range
  task automatic t_code;
    logic [8:0] v[3] = '{9'h100, 9'h080, 9'h000};
    cfg(8'h00);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge lclk);
      fix      <= 1'b1;
      fix_code <= v[i];
      repeat (24) @(posedge lclk);
      for (int k = 0; k < 4; k++)
      begin
        cmp("fixed code", 32'(v[i]), 32'(port[k]));
        cmp("in range", 32'(i < 2), 32'(inr[k]));
        cmp("offset removed", 32'(v[i] ^ 9'h100), 32'(twos[k]));
      end
    end
  endtask : t_code

  initial
  begin
    repeat (6) @(posedge mclk);
    cmp("reset input select", 32'h0000_00e4, 32'(isel));
    cmp("reset ports", 32'h0, 32'(port[0] | port[1] | port[2] | port[3]));
    cmp("reset strobes", 32'h0, 32'(rdy));
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_regs;
    t_run(8'h00, 8'he4, 16'hf0f0, 32'h0e0e_0e0e);
    t_run(8'h0d, 8'hf5, 16'h5a5a, 32'h0e10_0e10);
    t_run(8'h41, 8'ha0, 16'h5a5a, 32'h0e10_0e10);
    t_run(8'h62, 8'haa, 16'h4281, 32'h0d0f_0e10);
    t_run(8'hb2, 8'hff, 16'h4281, 32'h0d0f_0e10);
    t_rm1;
    t_code;
    final_report;
  end
endmodule : qaops_seq_tb
`default_nettype wire
